// ---- hw/pgs_pkg.sv ----
// package: register map, field positions and reset values of the power-good status bank
package pgs_pkg;
  // ------------------------------------------------------------
  // register offsets on the serial register port
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_A = 8'hE7;
  localparam logic [7:0] ADDR_STATUS_B = 8'hE8;
  localparam logic [7:0] ADDR_MISC = 8'hE9;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_STATUS_A = 8'h00;
  localparam logic [7:0] RST_STATUS_B = 8'h00;
  localparam logic [7:0] RST_MISC = 8'h02;
  localparam logic [2:0] STATUS_B_RSVD_READ = 3'h7;
  // ------------------------------------------------------------
  // misc control field positions
  // ------------------------------------------------------------
  localparam int BIT_TERM_OVR = 7;
  localparam int BIT_TERM_MASK = 6;
  localparam int BIT_CHIP_OVR = 5;
  localparam int BIT_CHIP_MASK = 4;
  localparam int BIT_DEEP_MASK = 3;
  localparam int BIT_SUSP_MASK = 2;
  localparam int BIT_ADAPTER_ROUTE = 1;
  localparam int BIT_TERM_DISCHARGE = 0;
  localparam int STATUS_B_LIVE_BITS = 5;
  // discharge resistance in ohms, carried for reference by the analog side
  localparam int DISCHARGE_OHMS = 100;
  // ------------------------------------------------------------
  // register port access states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PGS_IDLE,
    PGS_WRITE,
    PGS_READ
  } pgs_access_t;
endpackage

// ---- hw/pgs_misc_reg.sv ----
// module: the read-write miscellaneous control register
`timescale 1ns/1ns
module pgs_misc_reg (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // write side
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  // stored value
  output logic [7:0] value_out
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      value_out <= pgs_pkg::RST_MISC; // RQ4
    end else if (clk_en_in && wr_en_in) begin
      value_out <= wr_data_in; // RQ4
    end
  end
endmodule

// ---- hw/pgs_power_good_bank.sv ----
// module: power-good status registers and miscellaneous enable and routing control
// Operation
// RQ1: status a at E7 reads eight live rail good bits, reset zero.
// RQ2: status b at E8 bits 4..0 report rail and sequence good, reset zero.
// RQ3: status b bits 7..5 always read as ones.
// RQ4: misc control at E9 is read-write, resets to 02.
// RQ5: with termination mask set, bit 7 turns termination rail on or off.
// RQ6: bit 6 clear lets termination pin control rail; set uses override bit.
// RQ7: bit 5 forces switched 3.3 V rail on while pin mask is zero.
// RQ8: bit 4 set ignores regulator enable pin, uses register control bit.
// RQ9: bit 3 set masks deep-sleep input to constant one in good tree.
// RQ10: bit 2 set masks suspend input to constant one in good tree.
// RQ11: bit 1 set routes adapter-present copy onto level shifter output.
// RQ12: bit 1 clear makes level shifter output follow its own input.
// RQ13: bit 0 set connects discharge resistance to termination rail.
// RQ14: status bits follow comparators live; writes to status are ignored.
`timescale 1ns/1ns
module pgs_power_good_bank (
  // clock, reset, clock enable
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // register port from the serial interface
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // comparator results
  input wire logic [7:0] rail_good_a_in,
  input wire logic [4:0] rail_good_b_in,
  // enable pins
  input wire logic termination_control_pin_in,
  input wire logic switched_3v3_enable_pin_in,
  input wire logic regulator_enable_pin_in,
  input wire logic rail_register_control_bit_in,
  // sleep inputs and level shifter
  input wire logic deep_sleep_input_in,
  input wire logic suspend_input_in,
  input wire logic level_shifter_input_in,
  input wire logic adapter_present_input_in,
  // outputs to rails and power-good tree
  output logic termination_rail_enable_out,
  output logic switched_3v3_rail_enable_out,
  output logic chipset_3v3_rail_enable_out,
  output logic deep_sleep_pg_term_out,
  output logic suspend_pg_term_out,
  output logic level_shifter_output_out,
  output logic termination_discharge_enable_out
);
  // ------------------------------------------------------------
  // live status and misc register
  // ------------------------------------------------------------
  logic [7:0] status_a;
  logic [7:0] status_b;
  logic [7:0] misc;
  logic misc_wr;
  logic [7:0] next_rdata;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_a <= pgs_pkg::RST_STATUS_A; // RQ1
    end else if (clk_en_in) begin
      status_a <= rail_good_a_in; // RQ14
    end
  end

  // upper bits are held at zero in storage; the read path forces them high
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_b <= pgs_pkg::RST_STATUS_B; // RQ2
    end else if (clk_en_in) begin
      status_b <= {3'h0, rail_good_b_in}; // RQ14
    end
  end

  // only the control register address accepts writes; status writes drop
  assign misc_wr = reg_wr_in && (reg_addr_in == pgs_pkg::ADDR_MISC); // RQ14

  pgs_misc_reg u_misc (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .wr_en_in(misc_wr),
    .wr_data_in(reg_wdata_in),
    .value_out(misc)
  );

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    case (reg_addr_in)
      pgs_pkg::ADDR_STATUS_A: next_rdata = status_a; // RQ1
      pgs_pkg::ADDR_STATUS_B: next_rdata = {pgs_pkg::STATUS_B_RSVD_READ, status_b[4:0]}; // RQ3
      pgs_pkg::ADDR_MISC: next_rdata = misc; // RQ4
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else if (clk_en_in) begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // enable routing
  // ------------------------------------------------------------
  always_comb begin
    if (misc[pgs_pkg::BIT_TERM_MASK]) begin
      termination_rail_enable_out = misc[pgs_pkg::BIT_TERM_OVR]; // RQ5
    end else begin
      termination_rail_enable_out = termination_control_pin_in; // RQ6
    end
  end

  // force-on only applies while the regulator pin still rules the chipset rail
  assign switched_3v3_rail_enable_out = (misc[pgs_pkg::BIT_CHIP_OVR] && !misc[pgs_pkg::BIT_CHIP_MASK])
                                        || switched_3v3_enable_pin_in; // RQ7
  assign chipset_3v3_rail_enable_out = misc[pgs_pkg::BIT_CHIP_MASK] ? rail_register_control_bit_in
                                       : regulator_enable_pin_in; // RQ8
  assign deep_sleep_pg_term_out = misc[pgs_pkg::BIT_DEEP_MASK] | deep_sleep_input_in; // RQ9
  assign suspend_pg_term_out = misc[pgs_pkg::BIT_SUSP_MASK] | suspend_input_in; // RQ10
  assign level_shifter_output_out = misc[pgs_pkg::BIT_ADAPTER_ROUTE] ? adapter_present_input_in // RQ11
                                    : level_shifter_input_in; // RQ12
  assign termination_discharge_enable_out = misc[pgs_pkg::BIT_TERM_DISCHARGE]; // RQ13

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_status_a_live;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in |=> status_a == $past(rail_good_a_in);
  endproperty
  a_status_a_live: assert property (p_status_a_live) else $error("status a not live"); // RQ1

  property p_status_b_read;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && reg_rd_in && reg_addr_in == pgs_pkg::ADDR_STATUS_B
      |=> reg_rvalid_out && reg_rdata_out[7:5] == 3'h7 && reg_rdata_out[4:0] == $past(status_b[4:0]);
  endproperty
  a_status_b_read: assert property (p_status_b_read) else $error("status b read wrong"); // RQ3

  property p_misc_write;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && misc_wr |=> misc == $past(reg_wdata_in);
  endproperty
  a_misc_write: assert property (p_misc_write) else $error("misc write lost"); // RQ4

  property p_status_write_ignored;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    reg_wr_in && reg_addr_in != pgs_pkg::ADDR_MISC |=> $stable(misc);
  endproperty
  a_status_write_ignored: assert property (p_status_write_ignored) else $error("stray write"); // RQ14

  property p_term_override;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    misc[pgs_pkg::BIT_TERM_MASK] |-> termination_rail_enable_out == misc[pgs_pkg::BIT_TERM_OVR];
  endproperty
  a_term_override: assert property (p_term_override) else $error("termination override"); // RQ5

  property p_term_pin;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !misc[pgs_pkg::BIT_TERM_MASK] |-> termination_rail_enable_out == termination_control_pin_in;
  endproperty
  a_term_pin: assert property (p_term_pin) else $error("termination pin"); // RQ6

  property p_force_on;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    misc[pgs_pkg::BIT_CHIP_OVR] && !misc[pgs_pkg::BIT_CHIP_MASK] |-> switched_3v3_rail_enable_out;
  endproperty
  a_force_on: assert property (p_force_on) else $error("force on"); // RQ7

  property p_reg_ctl;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    misc[pgs_pkg::BIT_CHIP_MASK] |-> chipset_3v3_rail_enable_out == rail_register_control_bit_in;
  endproperty
  a_reg_ctl: assert property (p_reg_ctl) else $error("register control"); // RQ8

  property p_masks;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (misc[pgs_pkg::BIT_DEEP_MASK] |-> deep_sleep_pg_term_out) and (misc[pgs_pkg::BIT_SUSP_MASK] |-> suspend_pg_term_out);
  endproperty
  a_masks: assert property (p_masks) else $error("sleep mask"); // RQ9 RQ10

  property p_shifter;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    level_shifter_output_out == (misc[pgs_pkg::BIT_ADAPTER_ROUTE] ? adapter_present_input_in : level_shifter_input_in);
  endproperty
  a_shifter: assert property (p_shifter) else $error("level shifter"); // RQ11 RQ12

  property p_discharge;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    termination_discharge_enable_out == misc[pgs_pkg::BIT_TERM_DISCHARGE];
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge"); // RQ13

  property p_status_b_live;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in |=> status_b[4:0] == $past(rail_good_b_in);
  endproperty
  a_status_b_live: assert property (p_status_b_live) else $error("status b not live"); // RQ2

  property p_status_a_read;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && reg_rd_in && reg_addr_in == pgs_pkg::ADDR_STATUS_A |=> reg_rvalid_out && reg_rdata_out == $past(status_a);
  endproperty
  a_status_a_read: assert property (p_status_a_read) else $error("status a read wrong"); // RQ1

  // a read in the same cycle as a write must still return the old value
  property p_misc_read;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && reg_rd_in && reg_addr_in == pgs_pkg::ADDR_MISC |=> reg_rvalid_out && reg_rdata_out == $past(misc);
  endproperty
  a_misc_read: assert property (p_misc_read) else $error("misc read wrong"); // RQ4

  property p_other_read;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && reg_rd_in && reg_addr_in != pgs_pkg::ADDR_STATUS_A && reg_addr_in != pgs_pkg::ADDR_STATUS_B
      && reg_addr_in != pgs_pkg::ADDR_MISC |=> reg_rdata_out == 8'h00;
  endproperty
  a_other_read: assert property (p_other_read) else $error("unmapped read not zero"); // RQ14

  property p_rvalid_idle;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && !reg_rd_in |=> !reg_rvalid_out;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("read answer without read"); // RQ1

  property p_rdata_hold;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && !reg_rd_in |=> $stable(reg_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // RQ1

  property p_misc_hold;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && !misc_wr |=> $stable(misc);
  endproperty
  a_misc_hold: assert property (p_misc_hold) else $error("misc changed without write"); // RQ4

  property p_status_a_write_ignored;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && reg_wr_in && reg_addr_in == pgs_pkg::ADDR_STATUS_A
      |=> status_a == $past(rail_good_a_in);
  endproperty
  a_status_a_write_ignored: assert property (p_status_a_write_ignored) else $error("status a written"); // RQ14

  property p_status_b_write_ignored;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && reg_wr_in && reg_addr_in == pgs_pkg::ADDR_STATUS_B
      |=> status_b[4:0] == $past(rail_good_b_in);
  endproperty
  a_status_b_write_ignored: assert property (p_status_b_write_ignored) else $error("status b written"); // RQ14

  // a low clock enable must hold every register, read answer included
  property p_frozen;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !clk_en_in |=> $stable(status_a) && $stable(status_b) && $stable(misc) && $stable(reg_rdata_out)
      && $stable(reg_rvalid_out);
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved while frozen"); // RQ14

  property p_switched_pin;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !misc[pgs_pkg::BIT_CHIP_OVR] |-> switched_3v3_rail_enable_out == switched_3v3_enable_pin_in;
  endproperty
  a_switched_pin: assert property (p_switched_pin) else $error("switched rail pin"); // RQ7

  property p_chip_pin;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !misc[pgs_pkg::BIT_CHIP_MASK] |-> chipset_3v3_rail_enable_out == regulator_enable_pin_in;
  endproperty
  a_chip_pin: assert property (p_chip_pin) else $error("regulator pin"); // RQ8

  property p_deep_follow;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !misc[pgs_pkg::BIT_DEEP_MASK] |-> deep_sleep_pg_term_out == deep_sleep_input_in;
  endproperty
  a_deep_follow: assert property (p_deep_follow) else $error("deep sleep term"); // RQ9

  property p_susp_follow;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !misc[pgs_pkg::BIT_SUSP_MASK] |-> suspend_pg_term_out == suspend_input_in;
  endproperty
  a_susp_follow: assert property (p_susp_follow) else $error("suspend term"); // RQ10

  property p_discharge_off_term;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !misc[pgs_pkg::BIT_TERM_DISCHARGE] |-> !termination_discharge_enable_out;
  endproperty
  a_discharge_off_term: assert property (p_discharge_off_term) else $error("discharge without bit"); // RQ13

  // ------------------------------------------------------------
  // cover points
  // ------------------------------------------------------------
  c_misc_write: cover property (@(posedge sys_clk_in) clk_en_in && misc_wr);
  c_read_b: cover property (@(posedge sys_clk_in) clk_en_in && reg_rd_in && reg_addr_in == pgs_pkg::ADDR_STATUS_B);
  c_route_off: cover property (@(posedge sys_clk_in) !misc[pgs_pkg::BIT_ADAPTER_ROUTE]);
  c_frozen_write: cover property (@(posedge sys_clk_in) !clk_en_in && reg_wr_in);
  c_term_forced: cover property (@(posedge sys_clk_in) misc[pgs_pkg::BIT_TERM_MASK] && misc[pgs_pkg::BIT_TERM_OVR]);
endmodule

// ---- test/pgs_ec_model.sv ----
// embedded controller model driving the register port of the power-good bank
`timescale 1ns/1ns
module pgs_ec_model (
  // clock
  input wire logic sys_clk_in,
  // register port towards the bank
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  // one strobe per access, raised and dropped at falling edges
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk_in);
    reg_wr_out = wr;
    reg_rd_out = ~wr;
    reg_addr_out = addr;
    reg_wdata_out = data;
    @(negedge sys_clk_in);
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    // idle bus carries the inverse so a stale address cannot pass for a live one
    reg_addr_out = ~addr;
    reg_wdata_out = ~data;
  endtask
endmodule

// ---- test/pgs_power_good_bank_tb_top.sv ----
// testbench: register reads, writes and pin routing of the power-good bank
`timescale 1ns/1ns
module pgs_power_good_bank_tb_top;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic reg_wr, reg_rd, rvalid;
  logic [7:0] addr, wdata, rdata, ga, pins, misc, o;
  logic [4:0] gb;
  logic [6:0] outs;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int compares = 0;
  int seed = 51910;
  always #4 sys_clk_in = ~sys_clk_in;
  pgs_ec_model pgs_ec_model_inst (.sys_clk_in(sys_clk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
    .reg_addr_out(addr), .reg_wdata_out(wdata));
  pgs_power_good_bank pgs_power_good_bank_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .rail_good_a_in(ga),
    .rail_good_b_in(gb), .termination_control_pin_in(pins[7]), .switched_3v3_enable_pin_in(pins[6]),
    .regulator_enable_pin_in(pins[5]), .rail_register_control_bit_in(pins[4]),
    .deep_sleep_input_in(pins[3]), .suspend_input_in(pins[2]), .level_shifter_input_in(pins[1]),
    .adapter_present_input_in(pins[0]), .termination_rail_enable_out(outs[6]),
    .switched_3v3_rail_enable_out(outs[5]), .chipset_3v3_rail_enable_out(outs[4]),
    .deep_sleep_pg_term_out(outs[3]), .suspend_pg_term_out(outs[2]),
    .level_shifter_output_out(outs[1]), .termination_discharge_enable_out(outs[0]));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    pgs_ec_model_inst.access(1'b0, a, 8'h00);
  endtask
  task automatic final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // read results are matched in issue order
  always @(negedge sys_clk_in) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("unexpected read answer at %0t", $time);
      end else begin
        check(rdata, exp_q.pop_front());
      end
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    bad_count++;
    final_report();
  end
  initial begin
    ga = 8'h00;
    gb = 5'h00;
    pins = 8'h01;
    repeat (5) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    check({7'h00, outs[1]}, 8'h01);
    rd(8'hE7, 8'h00);
    rd(8'hE8, 8'hE0);
    rd(8'hE9, 8'h02);
    rd(8'hE6, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk_in);
      ga = 8'($random(seed));
      gb = 5'($random(seed));
      repeat (3) @(negedge sys_clk_in);
      rd(8'hE7, ga);
      rd(8'hE8, {3'h7, gb});
      pgs_ec_model_inst.access(1'b1, 8'hE7, 8'($random(seed)));
      pgs_ec_model_inst.access(1'b1, 8'hE8, 8'($random(seed)));
      rd(8'hE7, ga);
      rd(8'hE8, {3'h7, gb});
    end
    // a write while the clock enable is low must not land
    // let the last read answer fall first, a frozen answer would stand and be taken twice
    @(negedge sys_clk_in);
    clk_en_in = 1'b0;
    pgs_ec_model_inst.access(1'b1, 8'hE9, 8'hFF);
    clk_en_in = 1'b1;
    rd(8'hE9, 8'h02);
    for (int i = 0; i < 40; i++) begin
      misc = 8'($random(seed));
      pgs_ec_model_inst.access(1'b1, 8'hE9, misc);
      pins = 8'($random(seed));
      @(posedge sys_clk_in);
      o[6] = misc[6] ? misc[7] : pins[7];
      o[5] = (misc[5] & ~misc[4]) | pins[6];
      o[4] = misc[4] ? pins[4] : pins[5];
      o[3] = misc[3] | pins[3];
      o[2] = misc[2] | pins[2];
      o[1] = misc[1] ? pins[0] : pins[1];
      o[0] = misc[0];
      check({1'b0, outs}, {1'b0, o[6:0]});
      rd(8'hE9, misc);
    end
    // a second reset mid-run must bring the control register back
    @(negedge sys_clk_in);
    reset_n_in = 1'b0;
    @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    check({7'h00, outs[1]}, {7'h00, pins[0]});
    rd(8'hE9, 8'h02);
    repeat (4) @(negedge sys_clk_in);
    check(8'(exp_q.size()), 8'h00);
    final_report();
  end
endmodule
